// ===== tlm_monitor.sv
`timescale 1ns/1ns
// t1 network loopback control, performance reports and error-rate monitor
// Contract
// - with line control enabled, an allowed line activate command enters line loopback
// - with line control enabled, a line release command ends line loopback
// - with line control disabled, line commands are ignored
// - line loopback control is enabled after reset
// - with payload control enabled, an allowed payload activate enters payload loopback
// - with payload control enabled, a payload release ends payload loopback
// - with payload control disabled, payload commands are ignored
// - payload commands, reports and error threshold act only in esf framing
// - enabled reports are built and sent once every second
// - reports are disabled after reset and then never sent
// - six thresholds from 10e-4 to 10e-9, default 10e-4
// - 10e-4: above 1535 errors in 10 s declares, otherwise clears
// - 10e-5: above 921 in 60 s or coarser criterion declares
// - 10e-6: above 92 in 60 s or coarser criterion declares
// - 10e-7: above 9 in 60 s or coarser criterion declares
// - 10e-8: above 41 in three 15 minute intervals or coarser declares
// - 10e-9: above 4 in three 15 minute intervals or coarser declares
// - circuit identifier up to 255 characters, empty at reset, writable, clearable
// - framing select d4 or esf, default esf, for both directions
module tlm_monitor
	import tlm_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYCLES_DEF
)(
	input  wire logic        mclk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// commands and errors from the t1 receive framer
	input  wire logic        line_loop_activate_cmd,
	input  wire logic        line_loop_release_cmd,
	input  wire logic        payload_loop_activate_cmd,
	input  wire logic        payload_loop_release_cmd,
	input  wire logic        line_loop_allowed,
	input  wire logic        payload_loop_allowed,
	input  wire logic        crc6_err,
	// status toward the line logic
	output logic             line_loopback,
	output logic             payload_loopback,
	output logic             excess_error_condition,
	output logic             esf_framing,
	output logic             perf_report_message,
	output logic [15:0]      perf_report_errors,
	output logic [1:0]       perf_report_seq
);

	localparam int SEC_W = $clog2(SEC_CYCLES);
	localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);

	typedef struct packed {
		logic                 line_en;
		logic                 pay_en;
		logic                 rpt_en;
		logic                 esf;
		tlm_thr_e             thr;
		logic [7:0]           cid_idx;
		logic                 line_lb;
		logic                 pay_lb;
		logic                 over_a;
		logic                 over_b;
		logic                 over_c;
		logic                 err_cond;
		logic [SEC_W-1:0]     sec_cnt;
		logic                 sec_tick;
		logic [15:0]          sec_errs;
		logic                 rpt_valid;
		logic [15:0]          rpt_errs;
		logic [1:0]           rpt_seq;
		logic [RPT_CNT_W-1:0] rpt_total;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
	} tlm_mon_s;

	tlm_mon_s st_ff;
	tlm_mon_s nxt_st;

	logic             acc_wr;
	logic             acc_rd;
	logic             cid_wr;
	logic             cid_clr;
	logic [7:0]       cid_char;
	logic [7:0]       cid_len;
	logic             done_a;
	logic             done_b;
	logic             done_c;
	logic [CNT_W-1:0] cnt_a;
	logic [CNT_W-1:0] cnt_b;
	logic [CNT_W-1:0] cnt_c;
	logic             esf_err;

	// =========================================================================
	// bus strobes
	// =========================================================================
	// a write lands at the edge where the master sees pready high
	assign acc_wr  = psel && penable && st_ff.pready && pwrite;
	assign acc_rd  = psel && penable && !st_ff.pready;
	assign cid_wr  = acc_wr && paddr == ADDR_CID_DATA;
	assign cid_clr = acc_wr && paddr == ADDR_CID_CTRL && pwdata[CID_CLR_BIT];
	assign esf_err = crc6_err && st_ff.esf;

	// =========================================================================
	// sub-blocks
	// =========================================================================
	tlm_cid_store u_cid (
		.mclk    (mclk),
		.rst     (rst),
		.wr_en   (cid_wr),
		.wr_char (pwdata[7:0]),
		.clr     (cid_clr),
		.rd_idx  (st_ff.cid_idx),
		.rd_char (cid_char),
		.length  (cid_len)
	);

	// windows only run in esf, where the crc6 exists at all
	tlm_err_window #(.WIN_SECS(WIN_A_SECS), .W(CNT_W)) u_win_a (
		.mclk      (mclk),
		.rst       (rst),
		.enable    (st_ff.esf),
		.sec_tick  (st_ff.sec_tick),
		.crc_err   (esf_err),
		.win_done  (done_a),
		.win_count (cnt_a)
	);

	tlm_err_window #(.WIN_SECS(WIN_B_SECS), .W(CNT_W)) u_win_b (
		.mclk      (mclk),
		.rst       (rst),
		.enable    (st_ff.esf),
		.sec_tick  (st_ff.sec_tick),
		.crc_err   (esf_err),
		.win_done  (done_b),
		.win_count (cnt_b)
	);

	tlm_err_window #(.WIN_SECS(WIN_C_SECS), .W(CNT_W)) u_win_c (
		.mclk      (mclk),
		.rst       (rst),
		.enable    (st_ff.esf),
		.sec_tick  (st_ff.sec_tick),
		.crc_err   (esf_err),
		.win_done  (done_c),
		.win_count (cnt_c)
	);

	// =========================================================================
	// next state
	// =========================================================================
	always_comb
	begin
		nxt_st           = st_ff;
		nxt_st.rpt_valid = 1'b0;
		nxt_st.sec_tick  = 1'b0;

		// apb: one wait state, so read data always comes from a flop
		nxt_st.pready = acc_rd;
		// writes never error and leave the last read data standing
		if (acc_rd && !pwrite)
		begin
			nxt_st.pslverr = 1'b0;
			nxt_st.prdata  = '0;
			case (paddr)
				ADDR_CTRL:     nxt_st.prdata = {25'h0000000, st_ff.thr, st_ff.esf,
					st_ff.rpt_en, st_ff.pay_en, st_ff.line_en};
				ADDR_STATUS:   nxt_st.prdata = {28'h0000000, st_ff.esf,
					st_ff.err_cond, st_ff.pay_lb, st_ff.line_lb};
				ADDR_CID_CTRL: nxt_st.prdata = {24'h000000, cid_len};
				ADDR_CID_DATA: nxt_st.prdata = {24'h000000, cid_char};
				ADDR_CID_IDX:  nxt_st.prdata = {24'h000000, st_ff.cid_idx};
				ADDR_RPT_CNT:  nxt_st.prdata = {16'h0000, st_ff.rpt_total};
				default:       nxt_st.pslverr = 1'b1;
			endcase
		end
		if (!pwrite && psel && penable && st_ff.pready)
			nxt_st.pslverr = 1'b0; // drop error once the read is taken
		if (acc_wr)
		begin
			case (paddr)
				ADDR_CTRL:
				begin
					nxt_st.line_en = pwdata[CTRL_LINE_EN];
					nxt_st.pay_en  = pwdata[CTRL_PAY_EN];
					nxt_st.rpt_en  = pwdata[CTRL_RPT_EN];
					nxt_st.esf     = pwdata[CTRL_ESF];
					// codes above the last setting fall back to the default
					if (pwdata[CTRL_THR_LSB +: 3] <= THR_E9)
						nxt_st.thr = tlm_thr_e'(pwdata[CTRL_THR_LSB +: 3]);
					else
						nxt_st.thr = THR_E4;
				end
				ADDR_CID_IDX:  nxt_st.cid_idx = pwdata[7:0];
				default:       nxt_st.cid_idx = st_ff.cid_idx;
			endcase
		end

		// line loopback: release wins over a simultaneous activate
		if (st_ff.line_en)
		begin
			if (line_loop_release_cmd)
				nxt_st.line_lb = 1'b0;
			else if (line_loop_activate_cmd && line_loop_allowed)
				nxt_st.line_lb = 1'b1;
		end

		// payload loopback needs esf as well as its own enable
		if (st_ff.pay_en && st_ff.esf)
		begin
			if (payload_loop_release_cmd)
				nxt_st.pay_lb = 1'b0;
			else if (payload_loop_activate_cmd && payload_loop_allowed)
				nxt_st.pay_lb = 1'b1;
		end

		// one-second tick from the system clock
		if (st_ff.sec_cnt == SEC_LAST)
		begin
			nxt_st.sec_cnt  = '0;
			nxt_st.sec_tick = 1'b1;
		end
		else
			nxt_st.sec_cnt = st_ff.sec_cnt + SEC_W'(1);

		// per-second error count feeds the report; saturates rather than wraps
		if (st_ff.sec_tick)
		begin
			nxt_st.sec_errs = 16'(esf_err);
			if (st_ff.rpt_en && st_ff.esf)
			begin
				nxt_st.rpt_valid = 1'b1;
				nxt_st.rpt_errs  = st_ff.sec_errs;
				nxt_st.rpt_seq   = st_ff.rpt_seq + 2'h1;
				nxt_st.rpt_total = st_ff.rpt_total + RPT_CNT_W'(1);
			end
		end
		else if (esf_err && st_ff.sec_errs != 16'hffff)
			nxt_st.sec_errs = st_ff.sec_errs + 16'h0001;

		// window verdicts; each window keeps its verdict until it closes again, and all are cleared in d4
		if (!st_ff.esf)
		begin
			nxt_st.over_a = 1'b0;
			nxt_st.over_b = 1'b0;
			nxt_st.over_c = 1'b0;
		end
		else
		begin
			if (done_a)
				nxt_st.over_a = cnt_a > LIM_E4_A;
			if (done_b)
				case (st_ff.thr)
					THR_E4:  nxt_st.over_b = 1'b0;
					THR_E5:  nxt_st.over_b = cnt_b > LIM_E5_B;
					THR_E6:  nxt_st.over_b = cnt_b > LIM_E6_B;
					default: nxt_st.over_b = cnt_b > LIM_E7_B;
				endcase
			if (done_c)
				case (st_ff.thr)
					THR_E8:  nxt_st.over_c = cnt_c > LIM_E8_C;
					THR_E9:  nxt_st.over_c = cnt_c > LIM_E9_C;
					default: nxt_st.over_c = 1'b0;
				endcase
		end
		nxt_st.err_cond = nxt_st.over_a || nxt_st.over_b || nxt_st.over_c;
	end

	// =========================================================================
	// registers
	// =========================================================================
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_ff         <= '0;
			st_ff.line_en <= 1'b1;
			st_ff.pay_en  <= 1'b1;
			st_ff.rpt_en  <= 1'b0;
			st_ff.esf     <= 1'b1;
			st_ff.thr     <= THR_E4;
		end
		else
			st_ff <= nxt_st;
	end

	assign prdata                 = st_ff.prdata;
	assign pready                 = st_ff.pready;
	assign pslverr                = st_ff.pslverr;
	assign line_loopback          = st_ff.line_lb;
	assign payload_loopback       = st_ff.pay_lb;
	assign excess_error_condition = st_ff.err_cond;
	assign esf_framing            = st_ff.esf;
	assign perf_report_message    = st_ff.rpt_valid;
	assign perf_report_errors     = st_ff.rpt_errs;
	assign perf_report_seq        = st_ff.rpt_seq;

	// =========================================================================
	// assertions
	// =========================================================================
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_LINE_ENTER: assert property (st_ff.line_en && line_loop_activate_cmd &&
		line_loop_allowed && !line_loop_release_cmd |=> line_loopback)
		else $error("line loopback not entered");
	AST_LINE_LEAVE: assert property (st_ff.line_en && line_loop_release_cmd
		|=> !line_loopback)
		else $error("line loopback not released");
	AST_LINE_IGNORE: assert property (!st_ff.line_en |=> $stable(line_loopback))
		else $error("line loopback moved while disabled");
	AST_RESET_DEF: assert property ($past(rst) |-> st_ff.line_en && !st_ff.rpt_en
		&& esf_framing && st_ff.thr == THR_E4)
		else $error("wrong control defaults after reset");
	AST_PAY_ENTER: assert property (st_ff.pay_en && esf_framing &&
		payload_loop_activate_cmd && payload_loop_allowed && !payload_loop_release_cmd
		|=> payload_loopback)
		else $error("payload loopback not entered");
	AST_PAY_LEAVE: assert property (st_ff.pay_en && esf_framing &&
		payload_loop_release_cmd |=> !payload_loopback)
		else $error("payload loopback not released");
	AST_PAY_IGNORE: assert property (!(st_ff.pay_en && esf_framing)
		|=> $stable(payload_loopback))
		else $error("payload loopback moved while ignored");
	AST_D4_QUIET: assert property (!esf_framing |=> !excess_error_condition
		&& !perf_report_message)
		else $error("esf-only function active in d4");
	AST_REPORT_TICK: assert property (perf_report_message |->
		$past(st_ff.sec_tick) && $past(st_ff.rpt_en) && $past(perf_report_seq) + 2'h1
		== perf_report_seq)
		else $error("report without enabled second tick");
	AST_REPORT_GAP: assert property (perf_report_message && SEC_CYCLES > 2
		|=> !perf_report_message [*2])
		else $error("reports closer than a second");
	AST_WIN_A: assert property (esf_framing && done_a && cnt_a > LIM_E4_A
		|=> excess_error_condition)
		else $error("10 s criterion not declared");
	AST_WIN_B: assert property (esf_framing && done_b && (st_ff.thr == THR_E5
		&& cnt_b > LIM_E5_B || st_ff.thr == THR_E6 && cnt_b > LIM_E6_B)
		|=> excess_error_condition)
		else $error("60 s criterion not declared");
	AST_CLEAR: assert property (esf_framing && done_a && done_b && !done_c &&
		!st_ff.over_c && cnt_a <= LIM_E4_A && cnt_b <= LIM_E7_B
		|=> !excess_error_condition)
		else $error("condition not cleared at window end");

	COV_LINE_LOOP: cover property (!line_loopback ##1 line_loopback);
	COV_PAY_LOOP: cover property (!payload_loopback ##1 payload_loopback);
	COV_REPORT: cover property (perf_report_message);
	COV_ERR_COND: cover property (excess_error_condition ##1 !excess_error_condition);

endmodule // tlm_monitor

// ===== tlm_pkg.sv
// constants shared by the t1 loopback and error-rate monitor
package tlm_pkg;

	// =========================================================================
	// clock and timing
	// =========================================================================
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SEC_NS         = 1000000000;
	localparam int SEC_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
	localparam int WIN_A_SECS     = 10;
	localparam int MIN_SECS       = 60;
	localparam int WIN_B_SECS     = MIN_SECS;
	localparam int INTERVAL_MIN   = 15;
	localparam int INTERVAL_COUNT = 3;
	localparam int WIN_C_SECS     = INTERVAL_COUNT * INTERVAL_MIN * MIN_SECS;

	// =========================================================================
	// error counting and limits (declared when the count is above the limit)
	// =========================================================================
	localparam int              CNT_W     = 25;
	localparam logic [CNT_W-1:0] LIM_E4_A = 25'h00005ff; // 1535 in 10 s
	localparam logic [CNT_W-1:0] LIM_E5_B = 25'h0000399; // 921 in 60 s
	localparam logic [CNT_W-1:0] LIM_E6_B = 25'h000005c; // 92 in 60 s
	localparam logic [CNT_W-1:0] LIM_E7_B = 25'h0000009; // 9 in 60 s
	localparam logic [CNT_W-1:0] LIM_E8_C = 25'h0000029; // 41 in 45 min
	localparam logic [CNT_W-1:0] LIM_E9_C = 25'h0000004; // 4 in 45 min

	typedef enum logic [2:0] {
		THR_E4 = 3'h0,
		THR_E5 = 3'h1,
		THR_E6 = 3'h2,
		THR_E7 = 3'h3,
		THR_E8 = 3'h4,
		THR_E9 = 3'h5
	} tlm_thr_e;

	// =========================================================================
	// register map (byte addresses)
	// =========================================================================
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_CID_CTRL = 8'h08;
	localparam logic [7:0] ADDR_CID_DATA = 8'h0c;
	localparam logic [7:0] ADDR_CID_IDX  = 8'h10;
	localparam logic [7:0] ADDR_RPT_CNT  = 8'h14;

	localparam int CTRL_LINE_EN = 0;
	localparam int CTRL_PAY_EN  = 1;
	localparam int CTRL_RPT_EN  = 2;
	localparam int CTRL_ESF     = 3;
	localparam int CTRL_THR_LSB = 4;
	localparam int CID_CLR_BIT  = 0;

	localparam int         CID_MAX_LEN = 255;
	localparam logic [7:0] CID_FULL    = 8'hff;
	localparam int         RPT_CNT_W   = 16;

endpackage

// ===== tlm_err_window.sv
`timescale 1ns/1ns
// fixed error-count window, closed by a number of one-second ticks
module tlm_err_window
	import tlm_pkg::*;
#(
	parameter int WIN_SECS = 10,
	parameter int W        = CNT_W
)(
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         enable,
	input  wire logic         sec_tick,
	input  wire logic         crc_err,
	output logic              win_done,
	output logic [W-1:0]      win_count
);

	localparam int                 SW   = $clog2(WIN_SECS + 1);
	localparam logic [SW-1:0]      LAST = SW'(WIN_SECS - 1);

	typedef struct packed {
		logic [SW-1:0] secs;
		logic [W-1:0]  cnt;
		logic          done;
		logic [W-1:0]  total;
	} tlm_win_s;

	tlm_win_s st_ff;
	tlm_win_s nxt_st;

	// =========================================================================
	// counting
	// =========================================================================
	// the error of the closing cycle goes into the next window, none is lost
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (!enable)
			nxt_st = '0;
		else if (sec_tick && st_ff.secs == LAST)
		begin
			nxt_st.done  = 1'b1;
			nxt_st.total = st_ff.cnt;
			nxt_st.secs  = '0;
			nxt_st.cnt   = W'(crc_err);
		end
		else
		begin
			if (sec_tick)
				nxt_st.secs = st_ff.secs + SW'(1);
			if (crc_err && st_ff.cnt != '1) // saturate
				nxt_st.cnt = st_ff.cnt + W'(1);
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign win_done  = st_ff.done;
	assign win_count = st_ff.total;

	AST_WIN_TICK: assert property (@(posedge mclk) disable iff (rst)
		win_done |-> $past(sec_tick))
		else $error("window closed without a second tick");

endmodule // tlm_err_window

// ===== tlm_cid_store.sv
`timescale 1ns/1ns
// circuit identifier text store, appended one character at a time
module tlm_cid_store
	import tlm_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_char,
	input  wire logic       clr,
	input  wire logic [7:0] rd_idx,
	output logic [7:0]      rd_char,
	output logic [7:0]      length
);

	typedef struct packed {
		logic [CID_MAX_LEN-1:0][7:0] text;
		logic [7:0]                  len;
	} tlm_cid_s;

	tlm_cid_s st_ff;
	tlm_cid_s nxt_st;

	// =========================================================================
	// storage
	// =========================================================================
	// clear only drops the length; stale text past it reads as zero anyway
	always_comb
	begin
		nxt_st = st_ff;
		if (clr)
			nxt_st.len = '0;
		else if (wr_en && st_ff.len != CID_FULL)
		begin
			nxt_st.text[st_ff.len] = wr_char;
			nxt_st.len             = st_ff.len + 8'h01;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rd_char = (rd_idx < st_ff.len) ? st_ff.text[rd_idx] : 8'h00;
	assign length  = st_ff.len;

	AST_CID_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		clr |=> length == 8'h00)
		else $error("identifier not empty after clear");

endmodule // tlm_cid_store

// ===== tlm_net_model.sv
// network-side model: loopback commands, unit permission levels and crc6 errors
`timescale 1ns/1ns
module tlm_net_model
(
	input  wire logic mclk,
	output logic      line_loop_activate_cmd,
	output logic      line_loop_release_cmd,
	output logic      payload_loop_activate_cmd,
	output logic      payload_loop_release_cmd,
	output logic      line_loop_allowed,
	output logic      payload_loop_allowed,
	output logic      crc6_err
);
	logic [3:0] cmds;

	// =========================================================================
	// command lines: idle low, one code raised for a single cycle at a time
	// =========================================================================
	assign line_loop_activate_cmd    = cmds[0];
	assign line_loop_release_cmd     = cmds[1];
	assign payload_loop_activate_cmd = cmds[2];
	assign payload_loop_release_cmd  = cmds[3];

	// permission starts low so a missed set-up shows as a refused loopback
	initial
	begin
		cmds                 = 4'h0;
		line_loop_allowed    = 1'b0;
		payload_loop_allowed = 1'b0;
		crc6_err             = 1'b0;
	end

	// idx 0 line activate, 1 line release, 2 payload activate, 3 payload release
	task automatic cmd(input int idx);
		cmds <= 4'h1 << idx;
		@(posedge mclk);
		cmds <= 4'h0;
	endtask

	// unit state level: whether that loopback may be performed now
	task automatic allow(input int idx, input logic v);
		if (idx == 0)
			line_loop_allowed <= v;
		else
			payload_loop_allowed <= v;
	endtask

	// n errors back to back, one per clock, the densest a line can give
	task automatic errs(input int n);
		crc6_err <= 1'b1;
		repeat (n) @(posedge mclk);
		crc6_err <= 1'b0;
	endtask
endmodule // tlm_net_model

// ===== tlm_monitor_tb.sv
// self-checking bench for the t1 loopback and error-rate monitor
`timescale 1ns/1ns
module tlm_monitor_tb
	import tlm_pkg::*;
;
	// a short second keeps the 60 s windows inside the run
	localparam int SEC = 200;
	logic        mclk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        lac, lrc, pac, prc, lal, pal, crc;
	logic        line_loopback, payload_loopback, excess_error_condition;
	logic        esf_framing, perf_report_message;
	logic [15:0] perf_report_errors;
	logic [1:0]  perf_report_seq, s;
	int          fail_count, samples_checked, cyc, pulses, gap, last, n;

	tlm_monitor #(.SEC_CYCLES(SEC)) tlm_monitor_inst (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_loop_activate_cmd(lac),
		.line_loop_release_cmd(lrc), .payload_loop_activate_cmd(pac),
		.payload_loop_release_cmd(prc), .line_loop_allowed(lal), .payload_loop_allowed(pal),
		.crc6_err(crc), .line_loopback(line_loopback), .payload_loopback(payload_loopback),
		.excess_error_condition(excess_error_condition), .esf_framing(esf_framing),
		.perf_report_message(perf_report_message), .perf_report_errors(perf_report_errors),
		.perf_report_seq(perf_report_seq));
	tlm_net_model tlm_net_model_inst (.mclk(mclk), .line_loop_activate_cmd(lac),
		.line_loop_release_cmd(lrc), .payload_loop_activate_cmd(pac),
		.payload_loop_release_cmd(prc), .line_loop_allowed(lal), .payload_loop_allowed(pal),
		.crc6_err(crc));

	// =========================================================================
	// clock, cycle count since reset release, report pulse bookkeeping
	// =========================================================================
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// cycle count lets the bench find window ends without reading the design
	always @(posedge mclk)
	begin
		if (rst)
		begin
			cyc    <= 0;
			pulses <= 0;
			last   <= 0;
		end
		else
		begin
			cyc <= cyc + 1;
			if (perf_report_message === 1'b1)
			begin
				pulses <= pulses + 1;
				gap    <= cyc - last;
				last   <= cyc;
			end
		end
	end

	// =========================================================================
	// shared tasks
	// =========================================================================
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one apb transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp, "register read");
	endtask

	// stop three edges into a fresh window of the given length
	task automatic wait_win(input int secs);
		do @(posedge mclk); while (cyc % (secs * SEC) != 3);
	endtask

	task automatic wait_pulse();
		int k;
		k = 0;
		do
		begin
			@(posedge mclk);
			k++;
		end while (perf_report_message !== 1'b1 && k < 2 * SEC);
		check(perf_report_message, 1'b1, "report pulse");
	endtask

	// =========================================================================
	// scenarios
	// =========================================================================
	task automatic t_reset();
		rd(ADDR_CTRL, 32'h0b);
		rd(ADDR_STATUS, 32'h08);
		rd(ADDR_CID_CTRL, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		check(e, 1'b1, "unmapped error");
		check(q, 32'h0, "unmapped data");
		apb(1'b1, 8'h18, 32'h0);
		check(e, 1'b0, "unmapped write error");
		repeat (3 * SEC) @(posedge mclk);
		check(pulses, 0, "no report while disabled");
		rd(ADDR_RPT_CNT, 32'h0);
	endtask

	// k 0 line, 1 payload; refused, entered, ignored when disabled, released
	task automatic t_loop(input int k);
		tlm_net_model_inst.allow(k, 1'b0);
		tlm_net_model_inst.cmd(2 * k);
		@(posedge mclk);
		check(k ? payload_loopback : line_loopback, 1'b0, "not allowed");
		tlm_net_model_inst.allow(k, 1'b1);
		tlm_net_model_inst.cmd(2 * k);
		@(posedge mclk);
		check(k ? payload_loopback : line_loopback, 1'b1, "activate");
		wr(ADDR_CTRL, 32'h0b ^ (32'h1 << k));
		tlm_net_model_inst.cmd(2 * k + 1);
		@(posedge mclk);
		check(k ? payload_loopback : line_loopback, 1'b1, "release off");
		wr(ADDR_CTRL, 32'h0b);
		tlm_net_model_inst.cmd(2 * k + 1);
		@(posedge mclk);
		check(k ? payload_loopback : line_loopback, 1'b0, "release");
		wr(ADDR_CTRL, 32'h0b ^ (32'h1 << k));
		tlm_net_model_inst.cmd(2 * k);
		@(posedge mclk);
		check(k ? payload_loopback : line_loopback, 1'b0, "activate off");
		wr(ADDR_CTRL, 32'h0b);
	endtask

	// one write past the limit must be dropped
	task automatic t_cid();
		wr(ADDR_CID_CTRL, 32'h1);
		for (int i = 0; i < 256; i++)
			wr(ADDR_CID_DATA, 32'h41 + i % 26);
		rd(ADDR_CID_CTRL, 32'd255);
		wr(ADDR_CID_IDX, 32'd254);
		rd(ADDR_CID_DATA, 32'h41 + 254 % 26);
		wr(ADDR_CID_IDX, 32'd255);
		rd(ADDR_CID_DATA, 32'h0);
		wr(ADDR_CID_CTRL, 32'h1);
		rd(ADDR_CID_CTRL, 32'h0);
	endtask

	task automatic t_report();
		wr(ADDR_CTRL, 32'h0f);
		wait_pulse();
		s = perf_report_seq;
		wait_pulse();
		@(posedge mclk);
		check(gap, SEC, "report spacing");
		check(perf_report_seq, 2'(s + 2'h1), "report sequence");
		rd(ADDR_RPT_CNT, 32'd2);
	endtask

	// 10e-4: 1536 in a window declares, 1535 in the next clears
	task automatic t_e4();
		wait_win(WIN_A_SECS);
		fork
			tlm_net_model_inst.errs(1536);
			begin
				wait_pulse();
				wait_pulse();
				check(perf_report_errors, 16'(SEC), "second errors");
			end
		join
		wait_win(WIN_A_SECS);
		check(excess_error_condition, 1'b1, "e4 declare");
		tlm_net_model_inst.errs(1535);
		wait_win(WIN_A_SECS);
		check(excess_error_condition, 1'b0, "e4 clear");
	endtask

	// 10e-6 and 10e-7 in turn: one above the limit declares, at the limit clears
	task automatic t_e7();
		wr(ADDR_CTRL, 32'h2f);
		wait_win(WIN_B_SECS);
		tlm_net_model_inst.errs(93);
		wait_win(WIN_B_SECS);
		check(excess_error_condition, 1'b1, "e6 declare");
		wr(ADDR_CTRL, 32'h3f);
		tlm_net_model_inst.errs(9);
		wait_win(WIN_B_SECS);
		check(excess_error_condition, 1'b0, "e7 clear");
		tlm_net_model_inst.errs(10);
		wait_win(WIN_B_SECS);
		check(excess_error_condition, 1'b1, "e7 declare");
		wr(ADDR_CTRL, 32'h2f);
		tlm_net_model_inst.errs(92);
		wait_win(WIN_B_SECS);
		check(excess_error_condition, 1'b0, "e6 clear");
	endtask

	// d4 silences payload commands and reports; then reports off in esf
	task automatic t_d4();
		wr(ADDR_CTRL, 32'h07);
		check(esf_framing, 1'b0, "d4 framing");
		rd(ADDR_STATUS, 32'h0);
		tlm_net_model_inst.cmd(2);
		@(posedge mclk);
		check(payload_loopback, 1'b0, "d4 payload");
		n = pulses;
		repeat (2 * SEC) @(posedge mclk);
		check(pulses, n, "d4 reports");
		wr(ADDR_CTRL, 32'h0b);
		n = pulses;
		repeat (3 * SEC) @(posedge mclk);
		check(pulses, n, "reports off");
	endtask

	// =========================================================================
	// main sequence, watchdog and verdict
	// =========================================================================
	task automatic end_of_test();
		$display("checks %0d failures %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		rst     = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_loop(0);
		t_loop(1);
		t_cid();
		t_report();
		t_e4();
		t_e7();
		t_d4();
		end_of_test();
	end

	// longest path is about 61k cycles
	initial
	begin
		#1000000;
		fail_count++;
		end_of_test();
	end
endmodule // tlm_monitor_tb
